// ---- common/pioc_pkg.sv ----
// What this block does
// - Two identical controllers serve 58 lines; 13 dedicated, the rest shared.
// - After reset every line is controller-owned input with its driver off.
// - Controller-owned lines work in both directions regardless of peripheral direction.
// - Own-enable gives line to controller, own-disable to peripheral, status reports owner.
// - Dedicated lines ignore ownership writes and read ownership status one.
// - Controller-owned line drives peripheral input to zero.
// - Output enable/disable set direction, status reads it, effective only when controller-owned.
// - Level set/clear program driven level; level status reads it back.
// - Controller input lines are undriven; peripheral lines take peripheral drive.
// - Pin level status returns the synchronized pin level, filtered on lines whose filter is enabled.
// - Filter enable/disable per line, status readable, works under either owner.
// - Any level change sets interrupt status, any owner, any direction.
// - Irq enable/disable set mask; interrupt asserts when masked status bit set.
// - Reading interrupt status returns it then clears all bits not set by a change in that same cycle.
// - All registers 32 bits, same bit position per line.
// - Unimplemented line bits ignore writes and read zero.
// - Open-drain enable/disable per line, drives low only, status readable, either owner.
package pioc_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_OWN_EN = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_OWN_DIS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_OWN_ST = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_OUT_EN = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_OUT_DIS = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_OUT_ST = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_FLT_EN = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_FLT_DIS = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_FLT_ST = 8'h28;
    localparam logic [ADDR_W-1:0] OFF_LVL_SET = 8'h30;
    localparam logic [ADDR_W-1:0] OFF_LVL_CLR = 8'h34;
    localparam logic [ADDR_W-1:0] OFF_LVL_ST = 8'h38;
    localparam logic [ADDR_W-1:0] OFF_PIN_ST = 8'h3C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_IRQ_DIS = 8'h44;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h48;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ST = 8'h4C;
    localparam logic [ADDR_W-1:0] OFF_OD_EN = 8'h50;
    localparam logic [ADDR_W-1:0] OFF_OD_DIS = 8'h54;
    localparam logic [ADDR_W-1:0] OFF_OD_ST = 8'h58;
    localparam logic [DATA_W-1:0] ZERO_W = 32'h0000_0000;
    localparam logic [DATA_W-1:0] UNMAPPED_RD = 32'h0000_0000;
    // Line maps of the two controllers: implemented lines and shared lines.
    localparam logic [DATA_W-1:0] FIRST_IMPL = 32'h3FFF_FFFF;
    localparam logic [DATA_W-1:0] FIRST_SHARED = 32'h3FFF_FFFF;
    localparam logic [DATA_W-1:0] SECOND_IMPL = 32'h0FFF_FFFF;
    localparam logic [DATA_W-1:0] SECOND_SHARED = 32'h0FFE_00D8;
    localparam int LINES_TOTAL = 58;
    localparam int LINES_DEDICATED = 13;

    typedef struct packed {
        logic [DATA_W-1:0] out;
        logic [DATA_W-1:0] oe;
    } pioc_drive_t;

    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [DATA_W-1:0] writedata;
        logic [3:0] byteenable;
    } pioc_bus_req_t;
endpackage

// ---- core/pioc_line_ctrl.sv ----
`timescale 1ns/1ns
module pioc_line_ctrl #(
    parameter logic [31:0] IMPL = 32'hFFFF_FFFF,
    parameter logic [31:0] SHARED = 32'hFFFF_FFFF
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Avalon-MM slave.
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Pins.
    input wire logic [31:0] pin_in,
    output logic [31:0] pin_out,
    output logic [31:0] pin_oe,
    // Peripheral side.
    input wire logic [31:0] periph_out,
    input wire logic [31:0] periph_oe,
    output logic [31:0] periph_in,
    // Interrupt.
    output logic irq
);
    logic [31:0] own_q, own_d;
    logic [31:0] dir_q, dir_d;
    logic [31:0] lvl_q, lvl_d;
    logic [31:0] flt_q, flt_d;
    logic [31:0] od_q, od_d;
    logic [31:0] msk_q, msk_d;
    logic [31:0] ist_q, ist_d;
    logic [31:0] clean;
    logic [31:0] clean_prev_q, clean_prev_d;
    logic [31:0] rdata_q, rdata_d;
    logic ack_q, ack_d;
    logic wait_q, wait_d;
    logic [31:0] pout_q, pout_d;
    logic [31:0] poe_q, poe_d;
    logic [31:0] pin_q, pin_d;
    logic irq_q, irq_d;
    logic [31:0] wmask;
    logic wr_hit, rd_hit;
    logic [31:0] chg;

    for (genvar i = 0; i < 32; i++) begin : g_line
        pioc_sync_filt u_sf (
            .clk(clk),
            .srst(srst),
            .pin_raw(pin_in[i]),
            .filt_en(flt_q[i]),
            .level_q(clean[i])
        );
    end

    always_comb begin
        wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
        wr_hit = avs_write && !ack_q;
        rd_hit = avs_read && !ack_q;
        own_d = own_q;
        dir_d = dir_q;
        lvl_d = lvl_q;
        flt_d = flt_q;
        od_d = od_q;
        msk_d = msk_q;
        rdata_d = rdata_q;
        ack_d = (avs_read || avs_write) && !ack_q;
        wait_d = !ack_d;
        if (wr_hit) begin
            unique case (avs_address)
                // ownership commands, dedicated lines ignore them.
                pioc_pkg::OFF_OWN_EN: own_d = own_q | (avs_writedata & wmask & SHARED);
                pioc_pkg::OFF_OWN_DIS: own_d = own_q & ~(avs_writedata & wmask & SHARED);
                pioc_pkg::OFF_OUT_EN: dir_d = dir_q | (avs_writedata & wmask);
                pioc_pkg::OFF_OUT_DIS: dir_d = dir_q & ~(avs_writedata & wmask);
                pioc_pkg::OFF_FLT_EN: flt_d = flt_q | (avs_writedata & wmask);
                pioc_pkg::OFF_FLT_DIS: flt_d = flt_q & ~(avs_writedata & wmask);
                pioc_pkg::OFF_LVL_SET: lvl_d = lvl_q | (avs_writedata & wmask);
                pioc_pkg::OFF_LVL_CLR: lvl_d = lvl_q & ~(avs_writedata & wmask);
                pioc_pkg::OFF_IRQ_EN: msk_d = msk_q | (avs_writedata & wmask);
                pioc_pkg::OFF_IRQ_DIS: msk_d = msk_q & ~(avs_writedata & wmask);
                pioc_pkg::OFF_OD_EN: od_d = od_q | (avs_writedata & wmask);
                pioc_pkg::OFF_OD_DIS: od_d = od_q & ~(avs_writedata & wmask);
                default: ;
            endcase
        end
        if (rd_hit) begin
            unique case (avs_address)
                pioc_pkg::OFF_OWN_ST: rdata_d = own_q;
                pioc_pkg::OFF_OUT_ST: rdata_d = dir_q;
                pioc_pkg::OFF_FLT_ST: rdata_d = flt_q;
                pioc_pkg::OFF_LVL_ST: rdata_d = lvl_q;
                pioc_pkg::OFF_PIN_ST: rdata_d = clean;
                pioc_pkg::OFF_IRQ_MASK: rdata_d = msk_q;
                pioc_pkg::OFF_IRQ_ST: rdata_d = ist_q;
                pioc_pkg::OFF_OD_ST: rdata_d = od_q;
                default: rdata_d = pioc_pkg::UNMAPPED_RD;
            endcase
            rdata_d = rdata_d & IMPL;
        end
        // unimplemented bits hold their reset value.
        own_d = (own_d & IMPL) | ~SHARED & IMPL;
        dir_d = dir_d & IMPL;
        lvl_d = lvl_d & IMPL;
        flt_d = flt_d & IMPL;
        od_d = od_d & IMPL;
        msk_d = msk_d & IMPL;
    end

    always_comb begin
        clean_prev_d = clean;
        chg = (clean ^ clean_prev_q) & IMPL;
        // sticky change flags, cleared on read, set wins.
        ist_d = ist_q;
        if (rd_hit && avs_address == pioc_pkg::OFF_IRQ_ST) begin
            ist_d = pioc_pkg::ZERO_W;
        end
        ist_d = ist_d | chg;
        irq_d = |(ist_d & msk_q);
        pin_d = clean & ~own_q;
        for (int i = 0; i < 32; i++) begin
            // owner selects drive source; any line bidirectional.
            pout_d[i] = own_q[i] ? lvl_q[i] : periph_out[i];
            poe_d[i] = own_q[i] ? dir_q[i] : periph_oe[i];
            if (od_q[i]) begin
                poe_d[i] = poe_d[i] & ~pout_d[i];
                pout_d[i] = 1'b0;
            end
        end
        poe_d = poe_d & IMPL;
        pout_d = pout_d & IMPL;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            own_q <= IMPL;
            dir_q <= pioc_pkg::ZERO_W;
            lvl_q <= pioc_pkg::ZERO_W;
            flt_q <= pioc_pkg::ZERO_W;
            od_q <= pioc_pkg::ZERO_W;
            msk_q <= pioc_pkg::ZERO_W;
            ist_q <= pioc_pkg::ZERO_W;
            clean_prev_q <= pioc_pkg::ZERO_W;
            rdata_q <= pioc_pkg::ZERO_W;
            ack_q <= 1'b0;
            wait_q <= 1'b1;
            pout_q <= pioc_pkg::ZERO_W;
            poe_q <= pioc_pkg::ZERO_W;
            pin_q <= pioc_pkg::ZERO_W;
            irq_q <= 1'b0;
        end else begin
            own_q <= own_d;
            dir_q <= dir_d;
            lvl_q <= lvl_d;
            flt_q <= flt_d;
            od_q <= od_d;
            msk_q <= msk_d;
            ist_q <= ist_d;
            clean_prev_q <= clean_prev_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            wait_q <= wait_d;
            pout_q <= pout_d;
            poe_q <= poe_d;
            pin_q <= pin_d;
            irq_q <= irq_d;
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign pin_out = pout_q;
    assign pin_oe = poe_q;
    assign periph_in = pin_q;
    assign irq = irq_q;

    a_dedicated_owned: assert property (@(posedge clk) disable iff (srst)
        (own_q & IMPL & ~SHARED) == (IMPL & ~SHARED)) else $error("dedicated line lost ownership");
    a_periph_zero: assert property (@(posedge clk) disable iff (srst)
        ((periph_in & $past(own_q)) == 32'h0000_0000)) else $error("peripheral input not zero");
    a_status_clear: assert property (@(posedge clk) disable iff (srst)
        (rd_hit && avs_address == pioc_pkg::OFF_IRQ_ST) |=> ((ist_q & ~$past(chg)) == 32'h0000_0000))
        else $error("status not cleared");
    a_change_sets: assert property (@(posedge clk) disable iff (srst)
        (chg != 32'h0000_0000) |=> ((ist_q & $past(chg)) == $past(chg))) else $error("change lost");
    a_irq_mask: assert property (@(posedge clk) disable iff (srst)
        ##1 irq == |(ist_q & $past(msk_q))) else $error("irq mismatch");
    a_od_low: assert property (@(posedge clk) disable iff (srst)
        ((pin_out & pin_oe & $past(od_q)) == 32'h0000_0000)) else $error("open drain drove high");
    a_dir_owned: assert property (@(posedge clk) disable iff (srst)
        ##1 ((pin_oe & $past(own_q) & ~$past(od_q)) == ($past(dir_q) & $past(own_q) & ~$past(od_q))))
        else $error("direction mismatch");
    a_unimpl_zero: assert property (@(posedge clk) disable iff (srst)
        ((avs_readdata & ~IMPL) == 32'h0000_0000)) else $error("unimplemented bit read one");
    // register access answers within one cycle.
    a_bus_answer: assert property (@(posedge clk) disable iff (srst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("bus did not answer");
    a_periph_drive: assert property (@(posedge clk) disable iff (srst)
        ##1 (((pin_oe ^ $past(periph_oe)) & ~$past(own_q) & ~$past(od_q) & IMPL) == 32'h0000_0000))
        else $error("peripheral drive not passed");
    a_level_owned: assert property (@(posedge clk) disable iff (srst)
        ##1 (((pin_out ^ $past(lvl_q)) & $past(own_q) & ~$past(od_q)) == 32'h0000_0000))
        else $error("driven level mismatch");
    // pin status returns the pin level.
    a_pin_status: assert property (@(posedge clk) disable iff (srst)
        (rd_hit && avs_address == pioc_pkg::OFF_PIN_ST) |=> (avs_readdata == ($past(clean) & IMPL)))
        else $error("pin status mismatch");
    // open drain releases a high level.
    a_od_release: assert property (@(posedge clk) disable iff (srst)
        ##1 ((pin_oe & $past(od_q) & $past(own_q) & $past(lvl_q)) == 32'h0000_0000))
        else $error("open drain drove a high level");
endmodule // pioc_line_ctrl

// ---- core/pioc_sync_filt.sv ----
`timescale 1ns/1ns
module pioc_sync_filt (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Raw pin level and filter select.
    input wire logic pin_raw,
    input wire logic filt_en,
    // Clean level.
    output logic level_q
);
    logic meta_q, meta_d;
    logic sync_q, sync_d;
    logic prev_q, prev_d;
    logic level_d;

    always_comb begin
        meta_d = pin_raw;
        sync_d = meta_q;
        prev_d = sync_q;
        if (filt_en) begin
            level_d = (sync_q == prev_q) ? sync_q : level_q;
        end else begin
            level_d = sync_q;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
            level_q <= level_d;
        end
    end

    a_filter_hold: assert property (@(posedge clk) disable iff (srst)
        (filt_en && (sync_q != prev_q)) |=> $stable(level_q)) else $error("filter passed a glitch");
endmodule // pioc_sync_filt

// ---- core/pioc_top.sv ----
`timescale 1ns/1ns
module pioc_top (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Avalon-MM slave, first controller.
    input wire logic [7:0] first_address,
    input wire logic first_read,
    input wire logic first_write,
    input wire logic [31:0] first_writedata,
    input wire logic [3:0] first_byteenable,
    output logic [31:0] first_readdata,
    output logic first_waitrequest,
    // Avalon-MM slave, second controller.
    input wire logic [7:0] second_address,
    input wire logic second_read,
    input wire logic second_write,
    input wire logic [31:0] second_writedata,
    input wire logic [3:0] second_byteenable,
    output logic [31:0] second_readdata,
    output logic second_waitrequest,
    // Pins.
    input wire logic [63:0] pin_in,
    output logic [63:0] pin_out,
    output logic [63:0] pin_oe,
    // Peripherals.
    input wire logic [63:0] periph_out,
    input wire logic [63:0] periph_oe,
    output logic [63:0] periph_in,
    // Interrupts.
    output logic first_irq,
    output logic second_irq
);
    pioc_line_ctrl #(.IMPL(pioc_pkg::FIRST_IMPL), .SHARED(pioc_pkg::FIRST_SHARED)) u_line_ctrl_first (
        .clk(clk), .srst(srst),
        .avs_address(first_address), .avs_read(first_read), .avs_write(first_write),
        .avs_writedata(first_writedata), .avs_byteenable(first_byteenable),
        .avs_readdata(first_readdata), .avs_waitrequest(first_waitrequest),
        .pin_in(pin_in[31:0]), .pin_out(pin_out[31:0]), .pin_oe(pin_oe[31:0]),
        .periph_out(periph_out[31:0]), .periph_oe(periph_oe[31:0]), .periph_in(periph_in[31:0]),
        .irq(first_irq)
    );
    pioc_line_ctrl #(.IMPL(pioc_pkg::SECOND_IMPL), .SHARED(pioc_pkg::SECOND_SHARED)) u_line_ctrl_second (
        .clk(clk), .srst(srst),
        .avs_address(second_address), .avs_read(second_read), .avs_write(second_write),
        .avs_writedata(second_writedata), .avs_byteenable(second_byteenable),
        .avs_readdata(second_readdata), .avs_waitrequest(second_waitrequest),
        .pin_in(pin_in[63:32]), .pin_out(pin_out[63:32]), .pin_oe(pin_oe[63:32]),
        .periph_out(periph_out[63:32]), .periph_oe(periph_oe[63:32]), .periph_in(periph_in[63:32]),
        .irq(second_irq)
    );
endmodule // pioc_top

// ---- verif/pioc_pin_model.sv ----
`timescale 1ns/1ns
module pioc_pin_model (
    // Device drive.
    input wire logic [63:0] pin_out,
    input wire logic [63:0] pin_oe,
    // Board drive.
    input wire logic [63:0] ext_lvl,
    input wire logic [63:0] ext_en,
    // Resolved level.
    output logic [63:0] pin_lvl
);
    always_comb begin
        for (int i = 0; i < 64; i++) begin
            pin_lvl[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_lvl[i] : 1'b1);
        end
    end
endmodule // pioc_pin_model

// ---- verif/test_parallel_io_controller.sv ----
`timescale 1ns/1ns
module test_parallel_io_controller;
    logic clk;
    logic srst;
    logic [7:0] adr [2];
    logic rd [2];
    logic wr [2];
    logic [31:0] wd [2];
    logic [31:0] rdat [2];
    logic wreq [2];
    logic [3:0] be [2];
    logic [1:0] irq;
    logic [63:0] pin_out, pin_oe, pin_lvl, ext_lvl, ext_en, p_out, p_oe, p_in;
    logic [31:0] impl [2];
    logic [31:0] shr [2];
    logic [31:0] r [2];
    logic [31:0] v [2];
    logic [31:0] o [2];
    logic [31:0] e [2];
    logic [31:0] x, q;
    logic [7:0] zr [6];
    int n_mismatch;
    int compares;

    pioc_top u_dut (
        .clk(clk), .srst(srst),
        .first_address(adr[0]), .first_read(rd[0]), .first_write(wr[0]), .first_writedata(wd[0]),
        .first_byteenable(be[0]), .first_readdata(rdat[0]), .first_waitrequest(wreq[0]),
        .second_address(adr[1]), .second_read(rd[1]), .second_write(wr[1]), .second_writedata(wd[1]),
        .second_byteenable(be[1]), .second_readdata(rdat[1]), .second_waitrequest(wreq[1]),
        .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe),
        .periph_out(p_out), .periph_oe(p_oe), .periph_in(p_in),
        .first_irq(irq[0]), .second_irq(irq[1])
    );

    pioc_pin_model u_pins (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .ext_en(ext_en), .pin_lvl(pin_lvl)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ticks(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic bus(input int c, input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq);
        int n;
        n = 0;
        adr[c] <= a;
        wd[c] <= d;
        rd[c] <= !w;
        wr[c] <= w;
        @(posedge clk);
        while (wreq[c] !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t no bus answer", $time);
            test_done();
        end
        rq = rdat[c];
        rd[c] <= 1'b0;
        wr[c] <= 1'b0;
        @(posedge clk);
    endtask

    task automatic bw(input int c, input logic [7:0] a, input logic [31:0] d);
        logic [31:0] t;
        bus(c, 1'b1, a, d, t);
    endtask

    task automatic rc(input int c, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] t;
        bus(c, 1'b0, a, 32'h0, t);
        chk(t, exp);
    endtask

    initial begin
        n_mismatch = 0;
        compares = 0;
        srst = 1'b1;
        for (int c = 0; c < 2; c++) begin
            adr[c] = 8'h00;
            rd[c] = 1'b0;
            wr[c] = 1'b0;
            wd[c] = 32'h0;
            be[c] = 4'hF;
        end
        impl = '{pioc_pkg::FIRST_IMPL, pioc_pkg::SECOND_IMPL};
        shr = '{pioc_pkg::FIRST_SHARED, pioc_pkg::SECOND_SHARED};
        zr = '{pioc_pkg::OFF_OUT_ST, pioc_pkg::OFF_LVL_ST, pioc_pkg::OFF_FLT_ST, pioc_pkg::OFF_IRQ_MASK,
               pioc_pkg::OFF_OD_ST, 8'hFC};
        x = $urandom(32'hA4A817A2);
        p_out = {$urandom, $urandom};
        p_oe = {$urandom, $urandom};
        ext_lvl = 64'h0;
        ext_en = 64'hFFFF_FFFF_FFFF_FFFF;
        ticks(10);
        srst <= 1'b0;
        @(posedge clk);
        chk($countones(~shr[0] & impl[0]) + $countones(~shr[1] & impl[1]), pioc_pkg::LINES_DEDICATED);
        chk($countones(impl[0]) + $countones(impl[1]), pioc_pkg::LINES_TOTAL);
        for (int c = 0; c < 2; c++) begin
            rc(c, pioc_pkg::OFF_OWN_ST, impl[c]);
            foreach (zr[i]) rc(c, zr[i], 32'h0);
            chk(pin_oe[32*c +: 32], 32'h0);
            chk(p_in[32*c +: 32], 32'h0);
        end
        $display("reset test done");
        for (int c = 0; c < 2; c++) begin
            r[c] = $urandom;
            v[c] = $urandom;
            o[c] = $urandom;
            ext_en[32*c +: 32] <= 32'h0;
            bw(c, pioc_pkg::OFF_OUT_EN, r[c]);
            bw(c, pioc_pkg::OFF_LVL_SET, v[c]);
            bw(c, pioc_pkg::OFF_LVL_CLR, v[c] & 32'h0000_FFFF);
            bw(c, pioc_pkg::OFF_OD_EN, o[c]);
            v[c] = v[c] & 32'hFFFF_0000;
            e[c] = r[c] & impl[c] & ~(o[c] & v[c]);
            ticks(8);
            rc(c, pioc_pkg::OFF_OUT_ST, r[c] & impl[c]);
            rc(c, pioc_pkg::OFF_LVL_ST, v[c] & impl[c]);
            rc(c, pioc_pkg::OFF_OD_ST, o[c] & impl[c]);
            chk(pin_oe[32*c +: 32], e[c]);
            chk(pin_out[32*c +: 32] & e[c], v[c] & e[c]);
            rc(c, pioc_pkg::OFF_PIN_ST, ((e[c] & v[c]) | ~e[c]) & impl[c]);
        end
        $display("output test done");
        for (int c = 0; c < 2; c++) begin
            bw(c, pioc_pkg::OFF_OWN_DIS, 32'hFFFF_FFFF);
            ticks(4);
            rc(c, pioc_pkg::OFF_OWN_ST, impl[c] & ~shr[c]);
            x = p_oe[32*c +: 32] & ~(o[c] & p_out[32*c +: 32]);
            chk(pin_oe[32*c +: 32] & impl[c], (shr[c] & x) | (~shr[c] & e[c]));
            chk(p_in[32*c +: 32] & impl[c], pin_lvl[32*c +: 32] & shr[c]);
            bw(c, pioc_pkg::OFF_OWN_EN, 32'hFFFF_FFFF);
            rc(c, pioc_pkg::OFF_OWN_ST, impl[c]);
            bw(c, pioc_pkg::OFF_OUT_DIS, 32'hFFFF_FFFF);
            bw(c, pioc_pkg::OFF_OD_DIS, 32'hFFFF_FFFF);
            rc(c, pioc_pkg::OFF_OUT_ST, 32'h0);
        end
        ext_en <= 64'hFFFF_FFFF_FFFF_FFFF;
        $display("owner test done");
        ticks(8);
        for (int c = 0; c < 2; c++) begin
            bus(c, 1'b0, pioc_pkg::OFF_IRQ_ST, 32'h0, q);
            be[c] <= 4'h2;
            bw(c, pioc_pkg::OFF_IRQ_EN, 32'hFFFF_FFFF);
            be[c] <= 4'hF;
            rc(c, pioc_pkg::OFF_IRQ_MASK, 32'h0000_FF00);
            bw(c, pioc_pkg::OFF_IRQ_DIS, 32'hFFFF_FFFF);
            bw(c, pioc_pkg::OFF_IRQ_EN, 32'h0000_0001);
            rc(c, pioc_pkg::OFF_IRQ_MASK, 32'h0000_0001);
            ext_lvl[32*c+5] <= 1'b1;
            ticks(8);
            chk(irq[c], 32'h0);
            rc(c, pioc_pkg::OFF_IRQ_ST, 32'h0000_0020);
            rc(c, pioc_pkg::OFF_IRQ_ST, 32'h0);
            ext_lvl[32*c] <= 1'b1;
            ticks(8);
            chk(irq[c], 32'h1);
            rc(c, pioc_pkg::OFF_IRQ_ST, 32'h0000_0001);
            ticks(2);
            chk(irq[c], 32'h0);
            bw(c, pioc_pkg::OFF_IRQ_DIS, 32'h0000_0001);
            rc(c, pioc_pkg::OFF_IRQ_MASK, 32'h0);
            bw(c, pioc_pkg::OFF_OUT_EN, 32'h0000_0004);
            bw(c, pioc_pkg::OFF_LVL_SET, 32'h0000_0004);
            ticks(8);
            rc(c, pioc_pkg::OFF_IRQ_ST, 32'h0000_0004);
            bw(c, pioc_pkg::OFF_OUT_DIS, 32'h0000_0004);
        end
        $display("change test done");
        srst <= 1'b1;
        ticks(2);
        srst <= 1'b0;
        @(posedge clk);
        for (int c = 0; c < 2; c++) begin
            rc(c, pioc_pkg::OFF_LVL_ST, 32'h0);
            rc(c, pioc_pkg::OFF_OWN_ST, impl[c]);
        end
        $display("second reset test done");
        for (int c = 0; c < 2; c++) begin
            bw(c, pioc_pkg::OFF_FLT_EN, 32'h0000_0002);
            rc(c, pioc_pkg::OFF_FLT_ST, 32'h0000_0002);
            ticks(8);
            bus(c, 1'b0, pioc_pkg::OFF_IRQ_ST, 32'h0, q);
            for (int f = 0; f < 2; f++) begin
                ext_lvl[32*c+1] <= 1'b1;
                @(posedge clk);
                ext_lvl[32*c+1] <= 1'b0;
                ticks(8);
                rc(c, pioc_pkg::OFF_IRQ_ST, (f == 1) ? 32'h0000_0002 : 32'h0);
                bw(c, pioc_pkg::OFF_FLT_DIS, 32'h0000_0002);
            end
        end
        $display("filter test done");
        test_done();
    end
endmodule // test_parallel_io_controller
